// >>> i2cs_pkg.sv
// package for the i2c slave with clock stretching and 10-bit addressing
// assumes one system clock; all bus pins are sampled into that clock
// =====================================================================
// constants and carriers
package i2cs_pkg;

	// slave sequencing states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_RX   = 2'b10,
		ST_TX   = 2'b11
	} i2cs_state_t;

	// rising-edge counts that mark the 8th and 9th scl pulse
	localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
	localparam logic [3:0] BIT_LAST     = 4'h9;
	localparam logic [3:0] BIT_CNT_RST  = 4'h0;

	// values after reset
	localparam logic [7:0] OWN_ADDR_RST  = 8'h00;
	localparam logic [7:0] BYTE_RST      = 8'h00;
	localparam logic       CLK_REL_RST   = 1'b1;
	localparam logic [1:0] SYNC_RST      = 2'h3;

	// software configuration bits
	typedef struct packed {
		logic addressHoldEnable;
		logic dataHoldEnable;
		logic stretchEnable;
		logic startEventEnable;
		logic tenBitEnable;
		logic ackDataBit;
	} i2cs_cfg_t;

	// status bits seen by software
	typedef struct packed {
		logic clockReleaseBit;
		logic portEventFlag;
		logic startSeen;
		logic stopSeen;
		logic ackStatusBit;
		logic updateAddressFlag;
		logic bufferFullFlag;
		logic readDirection;
		logic ackTimingFlag;
	} i2cs_stat_t;

endpackage : i2cs_pkg

// >>> i2cs_pin_sync.sv
// two-stage synchroniser for scl and sda with scl edge detection
// assumes pins are asynchronous to clk; edges are found on stage two only
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// pin synchroniser
module i2cs_pin_sync (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// raw pins, bit 0 scl, bit 1 sda
	input  wire logic [1:0] pinIn,
	// synchronised levels and scl edges
	output var  logic       sclSync,
	output var  logic       sdaSync,
	output var  logic       sclRise,
	output var  logic       sclFall
);
	logic [1:0] stageOne_r;
	logic [1:0] stageTwo_r;
	logic       sclPrev_r;

	// one two-flop chain per pin
	for (genvar i = 0; i < 2; i++) begin : gSync
		always_ff @(posedge clk) begin
			if (rst) begin
				stageOne_r[i] <= 1'b1;
				stageTwo_r[i] <= 1'b1;
			end else begin
				stageOne_r[i] <= pinIn[i];
				stageTwo_r[i] <= stageOne_r[i];
			end
		end
	end

	// previous scl for edge finding
	always_ff @(posedge clk) begin
		if (rst) begin
			sclPrev_r <= 1'b1;
		end else begin
			sclPrev_r <= stageTwo_r[0];
		end
	end

	assign sclSync = stageTwo_r[0];
	assign sdaSync = stageTwo_r[1];
	assign sclRise = stageTwo_r[0] & ~sclPrev_r;
	assign sclFall = ~stageTwo_r[0] & sclPrev_r;
endmodule : i2cs_pin_sync
`default_nettype wire

// >>> i2cs_cond_detect.sv
// start and stop condition detector on synchronised scl and sda
// assumes inputs are already in the clk domain
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// start / stop detector
module i2cs_cond_detect (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// synchronised lines
	input  wire logic sclSync,
	input  wire logic sdaSync,
	// one-cycle condition pulses
	output var  logic startPulse,
	output var  logic stopPulse
);
	logic sdaPrev_r;

	// sda history
	always_ff @(posedge clk) begin
		if (rst) begin
			sdaPrev_r <= 1'b1;
		end else begin
			sdaPrev_r <= sdaSync;
		end
	end

	// sda change while scl high marks a condition
	assign startPulse = sclSync & sdaPrev_r & ~sdaSync;
	assign stopPulse  = sclSync & ~sdaPrev_r & sdaSync;
endmodule : i2cs_cond_detect
`default_nettype wire

// >>> i2cs_slave.sv
// i2c slave: address hold, 10-bit addressing, software clock release
// assumes an external master on scl/sda and software on the plain ports
// Function
// - address hold: release bit cleared, event after 8th fall
// - start sets start-seen, event if enabled
// - software ack level driven in ninth pulse only with the address or data hold for that byte on, else ack
// - read address ack: clear release, stretch, event
// - master ack captured on 9th pulse
// - master nack releases scl and sda
// - 10-bit high byte match sets update-address, event
// - update-address flag stretches without release bit
// - own-address write ends update-address stretch
// - low byte miss: event, update-address, no buffer-full
// - stretch enable clears release after every write ack except the 10-bit high byte
// - buffer-full never affects stretching
// - data hold: release cleared after 8th fall
// - 10-bit holds behave like 7-bit holds
// - scl pulled low only after sampled low
// - scl held until software sets release bit, or for update-address until an own-address write
// - after nack go idle until start
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// slave top
module i2cs_slave (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// scl open-drain pin
	input  wire logic               sclIn,
	output var  logic               sclOut,
	output var  logic               sclOe,
	// sda open-drain pin
	input  wire logic               sdaIn,
	output var  logic               sdaOut,
	output var  logic               sdaOe,
	// software configuration
	input  wire i2cs_pkg::i2cs_cfg_t cfg,
	// software strobes
	input  wire logic               clkReleaseSet,
	input  wire logic               eventClear,
	input  wire logic               bufferRead,
	input  wire logic               txLoad,
	input  wire logic [7:0]         txData,
	input  wire logic               ownAddrWrite,
	input  wire logic [7:0]         ownAddrData,
	// software view
	output var  i2cs_pkg::i2cs_stat_t stat,
	output var  logic [7:0]         rxData,
	output var  logic [7:0]         ownAddress
);
	// =================================================================
	// signals
	i2cs_pkg::i2cs_state_t state_r, state_nxt;
	logic [3:0] bitCnt_r;
	logic [7:0] shift_r, txShift_r, rxData_r, ownAddr_r;
	logic       sclS, sdaS, sclRise, sclFall, startDet, stopDet;
	logic       sclOe_r, sdaOe_r, sdaOe_nxt;
	logic       ckp_r, event_r, bufFull_r, ua_r, startSeen_r, stopSeen_r;
	logic       ack_status_bit_r, ack_timing_flag_r, readDir_r, matched_r;
	logic       tenLow_r, tenMatched_r, ackPhase_r, ackUseSw_r, txDrive_r;
	logic       fall8, fall9, matchNow, ackSent, holdReq;
	logic       ckpClr, evtSet, uaSet, bfSet, bfClr, rxCapture;
	logic       tenLow_nxt, tenMatched_nxt, txStart, ackArm;

	// =================================================================
	// pin sampling
	// synchronise the bus lines before anything reads them
	i2cs_pin_sync uSync (
		.clk     (clk),
		.rst     (rst),
		.pinIn   ({sdaIn, sclIn}),
		.sclSync (sclS),
		.sdaSync (sdaS),
		.sclRise (sclRise),
		.sclFall (sclFall)
	);

	// start and stop from synchronised lines
	i2cs_cond_detect uCond (
		.clk        (clk),
		.rst        (rst),
		.sclSync    (sclS),
		.sdaSync    (sdaS),
		.startPulse (startDet),
		.stopPulse  (stopDet)
	);

	// =================================================================
	// decode
	// 8th and 9th falling edges counted by preceding rising edges
	assign fall8 = sclFall && bitCnt_r == i2cs_pkg::BIT_ACK_SLOT;
	assign fall9 = sclFall && bitCnt_r == i2cs_pkg::BIT_LAST;

	// address compare, low byte whole, otherwise seven upper bits
	assign matchNow = tenLow_r ? (shift_r == ownAddr_r) :
		(shift_r[7:1] == ownAddr_r[7:1]) &&
		(!cfg.tenBitEnable || !shift_r[0] || tenMatched_r);

	// ack actually given in the ninth slot
	assign ackSent = ackPhase_r && (ackUseSw_r ? !cfg.ackDataBit : 1'b1);

	// stretch request, update-address needs no release bit
	assign holdReq = !ckp_r || ua_r;

	// =================================================================
	// sequencing decisions
	always_comb begin
		state_nxt      = state_r;
		ckpClr         = 1'b0;
		evtSet         = 1'b0;
		uaSet          = 1'b0;
		bfSet          = 1'b0;
		bfClr          = 1'b0;
		rxCapture      = 1'b0;
		ackArm         = 1'b0;
		txStart        = 1'b0;
		tenLow_nxt     = tenLow_r;
		tenMatched_nxt = tenMatched_r;
		if (stopDet) begin
			state_nxt      = i2cs_pkg::ST_IDLE;
			tenLow_nxt     = 1'b0;
			tenMatched_nxt = 1'b0;
		end else if (startDet) begin
			state_nxt  = i2cs_pkg::ST_ADDR;
			tenLow_nxt = 1'b0;
			evtSet     = cfg.startEventEnable;
		end else if (fall8) begin
			case (state_r)
				i2cs_pkg::ST_ADDR: begin
					if (matchNow) begin
						rxCapture = 1'b1;
						bfSet     = 1'b1;
						ackArm    = 1'b1;
						// hold before the ack slot
						ckpClr    = cfg.addressHoldEnable;
						evtSet    = cfg.addressHoldEnable;
					end else if (!tenLow_r) begin
						state_nxt = i2cs_pkg::ST_IDLE;
					end
				end
				i2cs_pkg::ST_RX: begin
					rxCapture = 1'b1;
					bfSet     = 1'b1;
					ackArm    = 1'b1;
					ckpClr    = cfg.dataHoldEnable;
					evtSet    = cfg.dataHoldEnable;
				end
				i2cs_pkg::ST_TX: begin
					bfClr = 1'b1;
				end
				default: begin
					state_nxt = i2cs_pkg::ST_IDLE;
				end
			endcase
		end else if (fall9) begin
			case (state_r)
				i2cs_pkg::ST_ADDR: begin
					if (tenLow_r) begin
						// low byte: flags set on match or miss
						uaSet      = 1'b1;
						evtSet     = 1'b1;
						tenLow_nxt = 1'b0;
						if (ackSent) begin
							tenMatched_nxt = 1'b1;
							state_nxt      = i2cs_pkg::ST_RX;
							ckpClr         = cfg.stretchEnable;
						end else begin
							state_nxt = i2cs_pkg::ST_IDLE;
						end
					end else if (!matched_r || !ackSent) begin
						state_nxt = i2cs_pkg::ST_IDLE;
					end else if (readDir_r) begin
						// read request always stretches
						state_nxt = i2cs_pkg::ST_TX;
						ckpClr    = 1'b1;
						evtSet    = 1'b1;
						txStart   = 1'b1;
					end else if (cfg.tenBitEnable && !tenMatched_r) begin
						// high byte write: await low byte
						uaSet      = 1'b1;
						evtSet     = 1'b1;
						tenLow_nxt = 1'b1;
					end else begin
						state_nxt = i2cs_pkg::ST_RX;
						evtSet    = 1'b1;
						ckpClr    = cfg.stretchEnable;
					end
				end
				i2cs_pkg::ST_RX: begin
					if (ackSent) begin
						evtSet = 1'b1;
						ckpClr = cfg.stretchEnable;
					end else begin
						state_nxt = i2cs_pkg::ST_IDLE;
					end
				end
				i2cs_pkg::ST_TX: begin
					evtSet = 1'b1;
					if (ack_status_bit_r) begin
						// master nack: drop the bus, wait for start
						state_nxt = i2cs_pkg::ST_IDLE;
					end else begin
						ckpClr  = 1'b1;
						txStart = 1'b1;
					end
				end
				default: begin
					state_nxt = i2cs_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// =================================================================
	// state and bit counting
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r  <= i2cs_pkg::ST_IDLE;
			bitCnt_r <= i2cs_pkg::BIT_CNT_RST;
		end else begin
			state_r <= state_nxt;
			// idle keeps the count at zero so an ignored frame cannot fake an 8th fall
			if (startDet || stopDet || fall9 || state_nxt == i2cs_pkg::ST_IDLE) begin
				bitCnt_r <= i2cs_pkg::BIT_CNT_RST;
			end else if (sclRise && state_r != i2cs_pkg::ST_IDLE && bitCnt_r != i2cs_pkg::BIT_LAST) begin
				bitCnt_r <= bitCnt_r + 4'h1;
			end
		end
	end

	// receive shifter samples sda on scl rise
	always_ff @(posedge clk) begin
		if (rst) begin
			shift_r <= i2cs_pkg::BYTE_RST;
		end else if (sclRise && bitCnt_r < i2cs_pkg::BIT_ACK_SLOT) begin
			shift_r <= {shift_r[6:0], sdaS};
		end
	end

	// =================================================================
	// transmit path
	// byte loaded by software, shifted on falling edges
	always_ff @(posedge clk) begin
		if (rst) begin
			txShift_r <= i2cs_pkg::BYTE_RST;
			txDrive_r <= 1'b0;
		end else begin
			if (txLoad) begin
				txShift_r <= txData;
			end else if (sclFall && state_r == i2cs_pkg::ST_TX && bitCnt_r != i2cs_pkg::BIT_CNT_RST &&
				bitCnt_r < i2cs_pkg::BIT_ACK_SLOT) begin
				txShift_r <= {txShift_r[6:0], 1'b0};
			end
			if (txStart) begin
				txDrive_r <= 1'b1;
			end else if (fall8 || state_nxt != i2cs_pkg::ST_TX) begin
				txDrive_r <= 1'b0;
			end
		end
	end

	// master ack taken on the ninth rising edge
	always_ff @(posedge clk) begin
		if (rst) begin
			ack_status_bit_r <= 1'b0;
		end else if (sclRise && state_r == i2cs_pkg::ST_TX && bitCnt_r == i2cs_pkg::BIT_ACK_SLOT) begin
			ack_status_bit_r <= sdaS;
		end
	end

	// =================================================================
	// ack slot bookkeeping
	always_ff @(posedge clk) begin
		if (rst) begin
			ackPhase_r <= 1'b0;
			ackUseSw_r <= 1'b0;
			matched_r  <= 1'b0;
			readDir_r  <= 1'b0;
			ack_timing_flag_r   <= 1'b0;
		end else begin
			if (fall8) begin
				ackPhase_r <= ackArm;
				ackUseSw_r <= state_r == i2cs_pkg::ST_ADDR ? cfg.addressHoldEnable : cfg.dataHoldEnable;
				ack_timing_flag_r   <= 1'b1;
				if (state_r == i2cs_pkg::ST_ADDR) begin
					matched_r <= matchNow;
					if (!tenLow_r) begin
						readDir_r <= shift_r[0];
					end
				end
			end else if (fall9 || startDet || stopDet) begin
				ackPhase_r <= 1'b0;
				ack_timing_flag_r   <= 1'b0;
			end
		end
	end

	// 10-bit address progress
	always_ff @(posedge clk) begin
		if (rst) begin
			tenLow_r     <= 1'b0;
			tenMatched_r <= 1'b0;
		end else begin
			tenLow_r     <= tenLow_nxt;
			tenMatched_r <= tenMatched_nxt;
		end
	end

	// =================================================================
	// software visible flags
	// clock release: hardware clear beats a same-cycle software set
	always_ff @(posedge clk) begin
		if (rst) begin
			ckp_r <= i2cs_pkg::CLK_REL_RST;
		end else if (ckpClr) begin
			ckp_r <= 1'b0;
		end else if (clkReleaseSet) begin
			ckp_r <= 1'b1;
		end
	end

	// event flag, a set beats a clear
	always_ff @(posedge clk) begin
		if (rst) begin
			event_r <= 1'b0;
		end else if (evtSet) begin
			event_r <= 1'b1;
		end else if (eventClear) begin
			event_r <= 1'b0;
		end
	end

	// buffer full and receive byte; full never feeds the stretch
	always_ff @(posedge clk) begin
		if (rst) begin
			bufFull_r <= 1'b0;
			rxData_r  <= i2cs_pkg::BYTE_RST;
		end else begin
			if (rxCapture) begin
				rxData_r <= shift_r;
			end
			if (bfSet || txLoad) begin
				bufFull_r <= 1'b1;
			end else if (bfClr || bufferRead) begin
				bufFull_r <= 1'b0;
			end
		end
	end

	// update-address flag and own address; a write ends the stretch
	always_ff @(posedge clk) begin
		if (rst) begin
			ua_r      <= 1'b0;
			ownAddr_r <= i2cs_pkg::OWN_ADDR_RST;
		end else begin
			if (uaSet) begin
				ua_r <= 1'b1;
			end else if (ownAddrWrite) begin
				ua_r <= 1'b0;
			end
			if (ownAddrWrite) begin
				ownAddr_r <= ownAddrData;
			end
		end
	end

	// start and stop seen
	always_ff @(posedge clk) begin
		if (rst) begin
			startSeen_r <= 1'b0;
			stopSeen_r  <= 1'b0;
		end else if (startDet) begin
			startSeen_r <= 1'b1;
			stopSeen_r  <= 1'b0;
		end else if (stopDet) begin
			startSeen_r <= 1'b0;
			stopSeen_r  <= 1'b1;
		end
	end

	// =================================================================
	// line drivers
	// sda low for ack or a zero data bit; released otherwise
	assign sdaOe_nxt = (ackPhase_r && (ackUseSw_r ? !cfg.ackDataBit : 1'b1)) ||
		(txDrive_r && !txShift_r[7]);

	// scl grabbed only once seen low, kept until released
	always_ff @(posedge clk) begin
		if (rst) begin
			sclOe_r <= 1'b0;
			sdaOe_r <= 1'b0;
		end else begin
			sclOe_r <= holdReq && (sclOe_r || !sclS);
			sdaOe_r <= sdaOe_nxt && !startDet && !stopDet;
		end
	end

	assign sclOut     = 1'b0;
	assign sdaOut     = 1'b0;
	assign sclOe      = sclOe_r;
	assign sdaOe      = sdaOe_r;
	assign rxData     = rxData_r;
	assign ownAddress = ownAddr_r;
	assign stat       = '{ckp_r, event_r, startSeen_r, stopSeen_r, ack_status_bit_r, ua_r, bufFull_r, readDir_r, ack_timing_flag_r};

	// =================================================================
	// checks
	AST_HOLD_AFTER_LOW: assert property (@(posedge clk) disable iff (rst)
		$rose(sclOe_r) |-> !$past(sclS)) else $error("scl pulled before sampled low");
	AST_RELEASE: assert property (@(posedge clk) disable iff (rst)
		(ckp_r && !ua_r) |=> !sclOe_r) else $error("scl held while released");
	AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (rst)
		(fall8 && state_r == i2cs_pkg::ST_ADDR && matchNow && cfg.addressHoldEnable && !stopDet && !startDet)
		|=> !ckp_r && event_r) else $error("address hold missed");
	AST_START: assert property (@(posedge clk) disable iff (rst)
		(startDet && !stopDet && cfg.startEventEnable) |=> startSeen_r && event_r) else $error("start not flagged");
	AST_READ_STRETCH: assert property (@(posedge clk) disable iff (rst)
		(fall9 && state_r == i2cs_pkg::ST_ADDR && matched_r && readDir_r && ackSent && !tenLow_r && !startDet && !stopDet)
		|=> !ckp_r && event_r && state_r == i2cs_pkg::ST_TX) else $error("read request not stretched");
	AST_ACK_CAPTURE: assert property (@(posedge clk) disable iff (rst)
		(sclRise && state_r == i2cs_pkg::ST_TX && bitCnt_r == i2cs_pkg::BIT_ACK_SLOT) |=> ack_status_bit_r == $past(sdaS))
		else $error("master ack not captured");
	AST_NACK_IDLE: assert property (@(posedge clk) disable iff (rst)
		(fall9 && state_r == i2cs_pkg::ST_TX && ack_status_bit_r && !startDet) |=> state_r == i2cs_pkg::ST_IDLE ##1 !sdaOe_r)
		else $error("nack did not release bus");
	AST_UA_RELEASE: assert property (@(posedge clk) disable iff (rst)
		(ownAddrWrite && !uaSet && ckp_r && !ckpClr) |=> !ua_r ##1 !sclOe_r) else $error("own address write kept scl");
	AST_DATA_HOLD: assert property (@(posedge clk) disable iff (rst)
		(fall8 && state_r == i2cs_pkg::ST_RX && cfg.dataHoldEnable && !startDet && !stopDet) |=> !ckp_r && bufFull_r)
		else $error("data hold missed");
endmodule : i2cs_slave
`default_nettype wire

// >>> i2cs_master_model.sv
// behavioural i2c bus master that faces the slave during the bench run
// assumes the bench resolves both open-drain lines with pull-ups
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// bus master model
module i2cs_master_model (
	// resolved bus lines
	input  wire logic sclLine,
	input  wire logic sdaLine,
	// master pull-downs, high pulls the line low
	output var  logic sclLow,
	output var  logic sdaLow,
	// set when a stretch outlasts the wait limit
	output var  logic stuck
);
	// quarter of the 125 ns scl period
	localparam realtime QTR = 31.25;

	// lines released, clock stands still until a frame starts
	initial begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
		stuck = 1'b0;
	end

	// release scl and wait while any other party still holds it low
	task automatic sclUp;
		int n;
		sclLow = 1'b0;
		n = 0;
		while (sclLine !== 1'b1 && n < 8000) begin
			#5;
			n++;
		end
		if (n >= 8000)
			stuck = 1'b1;
	endtask : sclUp

	// one bit: data changes mid-low, sampled at the end of the high phase just before scl falls
	task automatic bitXfer(input logic b, output logic r);
		#QTR sdaLow = ~b;
		#QTR sclUp();
		#(2 * QTR) r = sdaLine;
		sclLow = 1'b1;
	endtask : bitXfer

	// start condition: sda falls while scl is high
	task automatic startCond;
		sdaLow = 1'b0;
		sclUp();
		#QTR sdaLow = 1'b1;
		#QTR sclLow = 1'b1;
	endtask : startCond

	// stop condition: sda rises while scl is high
	task automatic stopCond;
		#QTR sdaLow = 1'b1;
		#QTR sclUp();
		#QTR sdaLow = 1'b0;
		#(2 * QTR);
	endtask : stopCond

	// write a byte msb first and return the slave's acknowledge level
	task automatic wByte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitXfer(d[i], r);
		end
		bitXfer(1'b1, ack);
	endtask : wByte

	// read a byte msb first, then answer with ack or nack
	task automatic rByte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitXfer(1'b1, r);
			d[i] = r;
		end
		bitXfer(nack, r);
	endtask : rByte

endmodule : i2cs_master_model
`default_nettype wire

// >>> tb.sv
// self-checking bench for the i2c slave with stretching and 10-bit addressing
// assumes the package, the slave design and the master model are compiled first
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// bench top
module tb;
	// software strobe masks {ownAddrWrite, txLoad, bufferRead, eventClear, clkReleaseSet}
	localparam logic [4:0] CR = 5'h01;
	localparam logic [4:0] EC = 5'h02;
	localparam logic [4:0] BR = 5'h04;
	localparam logic [4:0] TL = 5'h08;
	localparam logic [4:0] OA = 5'h10;

	logic                 clk, rst, sclLow, sdaLow, stuck, ack;
	logic                 sclOe, sdaOe, sclOut, sdaOut;
	logic [4:0]           strb;
	logic [7:0]           txData, ownAddrData, rxData, ownAddress, got, d0, d1;
	logic [2:0]           evQ[$];
	i2cs_pkg::i2cs_cfg_t  cfg;
	i2cs_pkg::i2cs_stat_t stat;
	int                   fails, checks;
	int                   seed = 32'he28e_d123;
	wire logic            sclLine, sdaLine;

	// open-drain lines with pull-ups
	assign sclLine = ~(sclLow | sclOe);
	assign sdaLine = ~(sdaLow | sdaOe);

	i2cs_slave uut (.clk(clk), .rst(rst), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .cfg(cfg), .clkReleaseSet(strb[0]),
		.eventClear(strb[1]), .bufferRead(strb[2]), .txLoad(strb[3]), .txData(txData),
		.ownAddrWrite(strb[4]), .ownAddrData(ownAddrData), .stat(stat), .rxData(rxData),
		.ownAddress(ownAddress));

	i2cs_master_model bus (.sclLine(sclLine), .sdaLine(sdaLine), .sclLow(sclLow), .sdaLow(sdaLow),
		.stuck(stuck));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// byte and bit comparisons
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chkBit(input string nm, input logic e, input logic g);
		chk(nm, {7'h00, e}, {7'h00, g});
	endtask : chkBit

	// one-cycle software strobe launched off the falling edge
	task automatic strobe(input logic [4:0] m);
		@(negedge clk) strb = m;
		@(negedge clk) strb = 5'h00;
	endtask : strobe
	task automatic setOwn(input logic [7:0] a);
		ownAddrData = a;
		strobe(OA);
	endtask : setOwn

	// wait for the event flag under a bound, then clear it
	task automatic waitEv;
		int n;
		n = 0;
		while (stat.portEventFlag !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		chkBit("eventSeen", 1'b1, stat.portEventFlag);
		strobe(EC);
	endtask : waitEv

	// closing verdict
	task automatic report_and_stop;
		if (fails == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	// monitor: each new event is compared with the oldest note {release, updateAddr, bufferFull}
	initial forever begin
		@(posedge stat.portEventFlag);
		@(negedge clk);
		if (evQ.size() == 0)
			chk("eventQueue", 8'h00, 8'hff);
		else
			chk("eventState", {5'h00, evQ.pop_front()},
				{5'h00, stat.clockReleaseBit, stat.updateAddressFlag, stat.bufferFullFlag});
	end

	// watchdog
	initial begin
		#200_000;
		fails++;
		report_and_stop();
	end

	// main sequence
	initial begin
		rst = 1'b1;
		cfg = 6'b00_0000;
		strb = 5'h00;
		txData = 8'h00;
		ownAddrData = 8'h00;
		fails = 0;
		checks = 0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		chk("statReset", 8'h00, stat[7:0]);
		chkBit("releaseReset", 1'b1, stat.clockReleaseBit);
		chk("ownReset", 8'h00, ownAddress);
		repeat (4) @(negedge clk);
		// 7-bit read, address hold, start event on; second byte refused by master
		setOwn(8'ha4);
		d0 = 8'($random(seed));
		d1 = 8'($random(seed));
		cfg = 6'b10_0100;
		evQ = '{3'b100, 3'b001, 3'b000, 3'b000, 3'b100};
		fork
			begin
				bus.startCond();
				bus.wByte(8'ha5, ack);
				chkBit("addrAck", 1'b0, ack);
				bus.rByte(1'b0, got);
				chk("txByte0", d0, got);
				bus.rByte(1'b1, got);
				chk("txByte1", d1, got);
				bus.stopCond();
			end
			begin
				waitEv();
				chkBit("startSeen", 1'b1, stat.startSeen);
				waitEv();
				chk("rxAddr", 8'ha5, rxData);
				chk("dirTiming", 8'h03, {6'h00, stat.readDirection, stat.ackTimingFlag});
				strobe(BR);
				strobe(CR);
				waitEv();
				repeat (8) @(negedge clk);
				chkBit("readStretch", 1'b1, sclOe);
				chkBit("sclHeld", 1'b0, sclLine);
				txData = d0;
				strobe(TL);
				strobe(CR);
				waitEv();
				chkBit("ackStat0", 1'b0, stat.ackStatusBit);
				txData = d1;
				strobe(TL);
				strobe(CR);
				waitEv();
				chkBit("ackStat1", 1'b1, stat.ackStatusBit);
				repeat (8) @(negedge clk);
				chk("linesFree", 8'h00, {6'h00, sclOe, sdaOe});
			end
		join
		@(negedge clk);
		chkBit("stopSeen", 1'b1, stat.stopSeen);
		// address hold with software nack, fresh start after the idle
		cfg = 6'b10_0001;
		evQ = '{3'b001};
		fork
			begin
				bus.startCond();
				bus.wByte(8'ha4, ack);
				chkBit("addrNack", 1'b1, ack);
				bus.stopCond();
			end
			begin
				waitEv();
				strobe(BR);
				strobe(CR);
			end
		join
		// 10-bit write: high byte, low byte, held data byte with stretch enable
		setOwn(8'hf4);
		d0 = 8'($random(seed));
		cfg = 6'b00_0010;
		evQ = '{3'b111, 3'b111, 3'b001, 3'b000};
		fork
			begin
				bus.startCond();
				bus.wByte(8'hf4, ack);
				chkBit("highAck", 1'b0, ack);
				bus.wByte(8'h5a, ack);
				chkBit("lowAck", 1'b0, ack);
				bus.wByte(d0, ack);
				chkBit("dataAck", 1'b0, ack);
				bus.stopCond();
			end
			begin
				waitEv();
				repeat (8) @(negedge clk);
				chk("uaStretch", 8'h03, {6'h00, sclOe, stat.clockReleaseBit});
				strobe(BR);
				setOwn(8'h5a);
				repeat (2) @(negedge clk);
				chkBit("uaRelease", 1'b0, sclOe);
				waitEv();
				strobe(BR);
				setOwn(8'hf4);
				cfg = 6'b01_1010;
				waitEv();
				chk("rxData", d0, rxData);
				strobe(BR);
				strobe(CR);
				waitEv();
				repeat (8) @(negedge clk);
				chkBit("senStretch", 1'b1, sclOe);
				strobe(CR);
			end
		join
		// 10-bit low byte miss
		@(negedge clk) cfg = 6'b00_0010;
		evQ = '{3'b111, 3'b110};
		fork
			begin
				bus.startCond();
				bus.wByte(8'hf4, ack);
				bus.wByte(8'h33, ack);
				chkBit("missNack", 1'b1, ack);
				bus.stopCond();
			end
			begin
				waitEv();
				strobe(BR);
				setOwn(8'h5a);
				waitEv();
				repeat (8) @(negedge clk);
				chkBit("missStretch", 1'b1, sclOe);
				setOwn(8'hf4);
			end
		join
		chk("ownAddr", 8'hf4, ownAddress);
		chk("notesLeft", 8'h00, 8'(evQ.size()));
		chkBit("busStuck", 1'b0, stuck);
		report_and_stop();
	end

endmodule : tb
`default_nettype wire
